//--- design/apbsc_cfg_regs.sv
// apbsc_cfg_regs.sv: aperture base, subsystem idents and capability pointer config bank
`timescale 1ns/10ps
`default_nettype none

module apbsc_cfg_regs (
	// clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     rstn,
	// configuration access
	input  wire apbsc_pkg::apbsc_cfg_req_t cfgReq,
	output logic                          cfgAck,
	output logic [31:0]                   cfgRdata,
	// neighbouring bridge registers
	input  wire logic                     apertureSizeSelect,
	input  wire logic                     apertureAccessEnable,
	// mode strap pin, high in integrated graphics mode
	input  wire logic                     integratedGraphicsModePin,
	// aperture range lookup
	input  wire logic                     apReqValid,
	input  wire logic [31:0]              apReqAddr,
	output logic                          apHit,
	output logic                          apRefused,
	// decoded state for the rest of the bridge
	output logic [31:0]                   apertureBase,
	output logic [15:0]                   subsystemVendorIdent,
	output logic [15:0]                   subsystemIdent,
	output logic                          integratedGraphicsMode
);

	//--------------------------------------------------------------------
	// declarations
	//--------------------------------------------------------------------
	apbsc_pkg::apbsc_cfg_rsp_t rsp_r;
	apbsc_pkg::apbsc_cfg_rsp_t rsp_nxt;

	logic        strapS1_r;
	logic        strapS2_r;
	logic        strapS3_r;
	logic [2:0]  strapFill_r;
	logic        strapDone_r;
	logic        gfxMode_r;

	logic [5:0]  baseHi_r;
	logic        baseSel_r;
	logic [31:0] baseValue;
	logic        baseWrite;

	logic        hitBase;
	logic        hitSubsys;
	logic        hitCap;
	logic        vendorWrite;
	logic        identWrite;
	logic [1:0]  vendorBe;
	logic [1:0]  identBe;
	logic [15:0] vendorValue;
	logic [15:0] identValue;
	logic        vendorLocked;
	logic        identLocked;

	logic        apInRange;
	logic        apHit_r;
	logic        apRefused_r;

	//--------------------------------------------------------------------
	// address decode
	//--------------------------------------------------------------------
	// dword match; both subsystem idents live in one dword
	assign hitBase   = cfgReq.addr[7:2] == apbsc_pkg::OFS_APERTURE_BASE[7:2];
	assign hitSubsys = cfgReq.addr[7:2] == apbsc_pkg::OFS_SUBSYS_VENDOR[7:2];
	assign hitCap    = cfgReq.addr[7:2] == apbsc_pkg::OFS_CAP_POINTER[7:2];

	// pick the two lanes that hold a 16-bit register from its offset
	function automatic logic [1:0] laneBe(input logic [7:0] ofs, input logic [3:0] be);
		laneBe = ofs[1] ? be[3:2] : be[1:0];
	endfunction

	assign vendorBe = laneBe(apbsc_pkg::OFS_SUBSYS_VENDOR, cfgReq.byteEn);
	assign identBe  = laneBe(apbsc_pkg::OFS_SUBSYS_IDENT, cfgReq.byteEn);

	// register writes; the base does not exist in integrated graphics mode
	assign baseWrite   = cfgReq.valid && cfgReq.write && hitBase && !gfxMode_r;
	assign vendorWrite = cfgReq.valid && cfgReq.write && hitSubsys && (|vendorBe);
	assign identWrite  = cfgReq.valid && cfgReq.write && hitSubsys && (|identBe);

	//--------------------------------------------------------------------
	// mode strap
	//--------------------------------------------------------------------
	// three stages from the pin; only stages two and three are compared
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			strapS1_r <= 1'b0;
			strapS2_r <= 1'b0;
			strapS3_r <= 1'b0;
		end
		else
		begin
			strapS1_r <= integratedGraphicsModePin;
			strapS2_r <= strapS1_r;
			strapS3_r <= strapS2_r;
		end
	end

	// marks which stages hold a real pin sample; the reset zeros in stages
	// two and three would otherwise agree at once and latch a stale mode
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			strapFill_r <= 3'h0;
		else
			strapFill_r <= {strapFill_r[1:0], 1'b1};
	end

	// latch the mode once after release; a strap must not move at run time
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			strapDone_r <= 1'b0;
			gfxMode_r   <= 1'b0;
		end
		else if (!strapDone_r && strapFill_r[2] && (strapS2_r == strapS3_r))
		begin
			strapDone_r <= 1'b1;
			gfxMode_r   <= strapS3_r;
		end
	end

	//--------------------------------------------------------------------
	// aperture base storage
	//--------------------------------------------------------------------
	// upper bits follow byte lane three only
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			baseHi_r <= apbsc_pkg::BASE_HI_RST;
		else if (baseWrite && cfgReq.byteEn[3])
			baseHi_r <= cfgReq.wdata[apbsc_pkg::BASE_HI_MSB:apbsc_pkg::BASE_HI_LSB];
	end

	// bit 25 is held at zero while the 64 MB size is selected, so a later
	// switch to 32 MB starts from a known base instead of a stale bit
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			baseSel_r <= 1'b0;
		else if (!apertureSizeSelect)
			baseSel_r <= 1'b0;
		else if (baseWrite && cfgReq.byteEn[3])
			baseSel_r <= cfgReq.wdata[apbsc_pkg::BASE_SEL_BIT];
	end

	// read view; constant fields never come from storage
	always_comb
	begin
		baseValue = '0;
		baseValue[apbsc_pkg::BASE_HI_MSB:apbsc_pkg::BASE_HI_LSB] = baseHi_r;
		baseValue[apbsc_pkg::BASE_SEL_BIT] = baseSel_r && apertureSizeSelect;
		baseValue[apbsc_pkg::BASE_PREF_BIT] = apbsc_pkg::BASE_PREF_VAL;
		baseValue[apbsc_pkg::BASE_TYPE_MSB:apbsc_pkg::BASE_TYPE_LSB] = apbsc_pkg::BASE_TYPE_VAL;
		baseValue[apbsc_pkg::BASE_MEM_BIT] = apbsc_pkg::BASE_MEM_VAL;
		if (gfxMode_r)
			baseValue = apbsc_pkg::APERTURE_BASE_RST_INT;
	end

	//--------------------------------------------------------------------
	// subsystem identification
	//--------------------------------------------------------------------
	apbsc_wo_reg #(
		.WIDTH   (16),
		.RST_VAL (apbsc_pkg::SUBSYS_VENDOR_RST)
	) u_vendor (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.wrEn    (vendorWrite),
		.byteEn  (vendorBe),
		.wdata   (apbsc_pkg::OFS_SUBSYS_VENDOR[1] ? cfgReq.wdata[31:16] : cfgReq.wdata[15:0]),
		.value   (vendorValue),
		.locked  (vendorLocked)
	);

	apbsc_wo_reg #(
		.WIDTH   (16),
		.RST_VAL (apbsc_pkg::SUBSYS_IDENT_RST)
	) u_ident (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.wrEn    (identWrite),
		.byteEn  (identBe),
		.wdata   (apbsc_pkg::OFS_SUBSYS_IDENT[1] ? cfgReq.wdata[31:16] : cfgReq.wdata[15:0]),
		.value   (identValue),
		.locked  (identLocked)
	);

	//--------------------------------------------------------------------
	// configuration answer
	//--------------------------------------------------------------------
	// every access is answered next cycle; unmapped dwords read zero and
	// writes to constant bits are simply dropped, never flagged
	always_comb
	begin
		rsp_nxt.ack   = cfgReq.valid;
		rsp_nxt.rdata = '0;
		if (cfgReq.valid && !cfgReq.write)
		begin
			if (hitBase)
				rsp_nxt.rdata = baseValue;
			else if (hitSubsys)
			begin
				rsp_nxt.rdata[15:0]  = apbsc_pkg::OFS_SUBSYS_VENDOR[1] ? identValue : vendorValue;
				rsp_nxt.rdata[31:16] = apbsc_pkg::OFS_SUBSYS_VENDOR[1] ? vendorValue : identValue;
			end
			else if (hitCap)
				rsp_nxt.rdata[7:0] = apbsc_pkg::CAP_POINTER_VAL;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			rsp_r <= '0;
		else
			rsp_r <= rsp_nxt;
	end

	assign cfgAck   = rsp_r.ack;
	assign cfgRdata = rsp_r.rdata;

	//--------------------------------------------------------------------
	// aperture range lookup
	//--------------------------------------------------------------------
	// bit 25 joins the compare only in the 32 MB size
	assign apInRange = !gfxMode_r
		&& (apReqAddr[apbsc_pkg::BASE_HI_MSB:apbsc_pkg::BASE_HI_LSB] == baseHi_r)
		&& (!apertureSizeSelect || (apReqAddr[apbsc_pkg::BASE_SEL_BIT] == baseSel_r));

	// refusal protects accesses made before the translation table is built
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			apHit_r     <= 1'b0;
			apRefused_r <= 1'b0;
		end
		else
		begin
			apHit_r     <= apReqValid && apInRange && apertureAccessEnable;
			apRefused_r <= apReqValid && apInRange && !apertureAccessEnable;
		end
	end

	assign apHit     = apHit_r;
	assign apRefused = apRefused_r;

	//--------------------------------------------------------------------
	// state towards the bridge
	//--------------------------------------------------------------------
	assign apertureBase           = baseValue;
	assign subsystemVendorIdent   = vendorValue;
	assign subsystemIdent         = identValue;
	assign integratedGraphicsMode = gfxMode_r;

	//--------------------------------------------------------------------
	// checks
	//--------------------------------------------------------------------
	chk_base_upper_write: assert property (@(posedge clk_sys) disable iff (!rstn)
		(baseWrite && cfgReq.byteEn[3]) |=> gfxMode_r || (apertureBase[31:26] == $past(cfgReq.wdata[31:26])))
		else $error("aperture base upper bits did not take write");

	chk_base_lane_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
		(cfgReq.valid && cfgReq.write && hitBase && !cfgReq.byteEn[3]) |=> $stable(baseHi_r))
		else $error("aperture base changed without its byte enable");

	chk_bit25_forced: assert property (@(posedge clk_sys) disable iff (!rstn)
		(cfgReq.valid && !cfgReq.write && hitBase && !apertureSizeSelect) |=> (cfgRdata[25] == 1'b0))
		else $error("aperture base bit 25 nonzero in 64 MB size");

	chk_bit25_write: assert property (@(posedge clk_sys) disable iff (!rstn)
		(baseWrite && cfgReq.byteEn[3] && apertureSizeSelect) ##1 apertureSizeSelect
		|-> gfxMode_r || (apertureBase[25] == $past(cfgReq.wdata[25])))
		else $error("aperture base bit 25 not writable in 32 MB size");

	chk_base_low_const: assert property (@(posedge clk_sys) disable iff (!rstn)
		(cfgReq.valid && !cfgReq.write && hitBase && !gfxMode_r) ##1 !$past(gfxMode_r)
		|-> (cfgRdata[24:0] == 25'h0000008))
		else $error("aperture base low bits not constant");

	chk_gfx_base_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
		gfxMode_r |-> (apertureBase == 32'h00000000) ##1 !apHit_r)
		else $error("aperture base present in integrated graphics mode");

	chk_cap_pointer: assert property (@(posedge clk_sys) disable iff (!rstn)
		(cfgReq.valid && !cfgReq.write && hitCap) |=> cfgAck && (cfgRdata == 32'h00000088))
		else $error("capability pointer read wrong");

	chk_ap_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
		(apReqValid && !apertureAccessEnable) |=> !apHit)
		else $error("aperture hit while access disabled");

	chk_ack_every: assert property (@(posedge clk_sys) disable iff (!rstn)
		cfgReq.valid |=> cfgAck ##1 (cfgAck == $past(cfgReq.valid)))
		else $error("configuration access not answered next cycle");

	chk_vendor_wo: assert property (@(posedge clk_sys) disable iff (!rstn)
		(vendorLocked && identLocked) |=> $stable(subsystemVendorIdent) && $stable(subsystemIdent))
		else $error("subsystem ident changed after first write");

endmodule

`default_nettype wire

//--- design/apbsc_pkg.sv
// apbsc_pkg.sv: constants and carriers for the aperture base and subsystem configuration bank
//------------------------------------------------------------------------
// What this block does
// - Aperture base bits 31:26 are readable and writable outside integrated mode.
// - Bit 25 reads zero, writes ignored, unless size select is one; then read/write.
// - Size select resets to zero, so bit 25 starts as constant zero (64 MB).
// - Aperture base bits 24:4 always read zero, whatever is written.
// - Aperture base bit 3 reads one: the aperture is prefetchable.
// - Aperture base bits 2:1 read 00: placeable anywhere in 32-bit space.
// - Aperture base bit 0 reads zero: memory range, not I/O.
// - Aperture base resets to 00000008h in both modes; 0 once the strap latches integrated mode.
// - Subsystem vendor ident is 16 bits at offset 2Ch, reset 0000h.
// - Subsystem ident is 16 bits at offset 2Eh, reset 0000h.
// - Each subsystem ident register takes only its first write, then reads back fixed.
// - Capability pointer at 34h is read-only and always returns 88h.
// - Aperture accesses are refused while aperture control bit 1 is clear.
// - Writes to constant bits complete normally and leave read value unchanged.
//------------------------------------------------------------------------
package apbsc_pkg;

	// configuration byte offsets; dword lookup uses bits 7:2
	localparam logic [7:0] OFS_APERTURE_BASE = 8'h10;
	localparam logic [7:0] OFS_SUBSYS_VENDOR = 8'h2c;
	localparam logic [7:0] OFS_SUBSYS_IDENT  = 8'h2e;
	localparam logic [7:0] OFS_CAP_POINTER   = 8'h34;

	// values after reset
	localparam logic [31:0] APERTURE_BASE_RST_EXT = 32'h00000008;
	localparam logic [31:0] APERTURE_BASE_RST_INT = 32'h00000000;
	localparam logic [5:0]  BASE_HI_RST           = 6'h00;
	localparam logic [15:0] SUBSYS_VENDOR_RST     = 16'h0000;
	localparam logic [15:0] SUBSYS_IDENT_RST      = 16'h0000;
	localparam logic [7:0]  CAP_POINTER_VAL       = 8'h88;

	// aperture base field positions
	localparam int BASE_HI_MSB   = 31;
	localparam int BASE_HI_LSB   = 26;
	localparam int BASE_SEL_BIT  = 25;
	localparam int BASE_ZERO_MSB = 24;
	localparam int BASE_ZERO_LSB = 4;
	localparam int BASE_PREF_BIT = 3;
	localparam int BASE_TYPE_MSB = 2;
	localparam int BASE_TYPE_LSB = 1;
	localparam int BASE_MEM_BIT  = 0;

	// aperture base constant field values
	localparam logic       BASE_PREF_VAL = 1'b1;
	localparam logic [1:0] BASE_TYPE_VAL = 2'b00;
	localparam logic       BASE_MEM_VAL  = 1'b0;

	// configuration request carrier; addr is the byte offset
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  addr;
		logic [3:0]  byteEn;
		logic [31:0] wdata;
	} apbsc_cfg_req_t;

	// configuration answer carrier
	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} apbsc_cfg_rsp_t;

endpackage

//--- design/apbsc_wo_reg.sv
// apbsc_wo_reg.sv: write-once identification register with byte lanes
`timescale 1ns/10ps
`default_nettype none

module apbsc_wo_reg #(
	parameter int          WIDTH = 16,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	// write strobe with byte lanes
	input  wire logic                 wrEn,
	input  wire logic [WIDTH/8-1:0]   byteEn,
	input  wire logic [WIDTH-1:0]     wdata,
	// stored state
	output logic      [WIDTH-1:0]     value,
	output logic                      locked
);

	logic [WIDTH-1:0] value_r;
	logic             locked_r;
	logic             takeWrite;

	// a write with no lane enabled does not spend the single chance
	assign takeWrite = wrEn && !locked_r && (|byteEn);

	//--------------------------------------------------------------------
	// storage
	//--------------------------------------------------------------------
	// only enabled lanes of the first write land; later writes are dropped
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			value_r <= RST_VAL;
		else if (takeWrite)
		begin
			for (int i = 0; i < WIDTH/8; i++)
				if (byteEn[i])
					value_r[i*8 +: 8] <= wdata[i*8 +: 8];
		end
	end

	// lock once taken; only reset reopens it
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			locked_r <= 1'b0;
		else if (takeWrite)
			locked_r <= 1'b1;
	end

	assign value  = value_r;
	assign locked = locked_r;

	//--------------------------------------------------------------------
	// checks
	//--------------------------------------------------------------------
	chk_wo_frozen: assert property (@(posedge clk_sys) disable iff (!rstn)
		locked_r |=> (value_r == $past(value_r)) && locked_r)
		else $error("write-once register changed after lock");

	chk_wo_first_lane: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wrEn && !locked_r && byteEn[0]) |=> (value_r[7:0] == $past(wdata[7:0])) && locked_r)
		else $error("first write to write-once register not taken");

endmodule

`default_nettype wire

//--- dv/apbsc_cfg_regs_tb.sv
// apbsc_cfg_regs_tb.sv: self-checking bench for the aperture base and subsystem configuration bank
`timescale 1ns/10ps
`default_nettype none

module apbsc_cfg_regs_tb;
	//------------------------------------------------------------------------
	// signals and model state
	//------------------------------------------------------------------------
	logic                      clk_sys;
	logic                      rstn;
	apbsc_pkg::apbsc_cfg_req_t cfgReq;
	logic                      cfgAck;
	logic [31:0]               cfgRdata;
	logic                      sizeSel;
	logic                      accEn;
	logic                      modePin;
	logic                      apReqValid;
	logic [31:0]               apReqAddr;
	logic                      apHit;
	logic                      apRefused;
	logic [31:0]               aperture_base;
	logic [15:0]               svIdent;
	logic [15:0]               sIdent;
	logic                      intMode;
	int                        num_errors;
	int                        num_checks;
	int                        cycles;
	// model: base high bits, bit 25, idents and their locks
	logic [5:0]                mHi;
	logic                      mB25;
	logic [15:0]               mSv;
	logic [15:0]               mSid;
	bit                        svLock;
	bit                        sidLock;
	bit                        mInt;

	apbsc_cfg_regs DUT (
		.clk_sys                   (clk_sys),
		.rstn                      (rstn),
		.cfgReq                    (cfgReq),
		.cfgAck                    (cfgAck),
		.cfgRdata                  (cfgRdata),
		.apertureSizeSelect        (sizeSel),
		.apertureAccessEnable      (accEn),
		.integratedGraphicsModePin (modePin),
		.apReqValid                (apReqValid),
		.apReqAddr                 (apReqAddr),
		.apHit                     (apHit),
		.apRefused                 (apRefused),
		.apertureBase              (aperture_base),
		.subsystemVendorIdent      (svIdent),
		.subsystemIdent            (sIdent),
		.integratedGraphicsMode    (intMode)
	);

	// 25 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// hang guard: the whole run needs well under 3000 cycles
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			num_errors++;
			report_and_stop();
		end
	end

	//------------------------------------------------------------------------
	// compare, model and bus tasks
	//------------------------------------------------------------------------
	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// integrated mode hides the aperture entirely
	function automatic logic [31:0] exp_base();
		if (mInt)
			return 32'h00000000;
		return {mHi, mB25 & sizeSel, 21'h0, 1'b1, 2'b00, 1'b0};
	endfunction

	function automatic logic [31:0] exp_read(input logic [7:0] a);
		case (a[7:2])
			6'h04:   return exp_base();
			6'h0b:   return {mSid, mSv};
			6'h0d:   return 32'h00000088;
			default: return 32'h00000000;
		endcase
	endfunction

	task automatic model_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
		if (a[7:2] == 6'h04 && !mInt && be[3])
		begin
			mHi = wd[31:26];
			if (sizeSel)
				mB25 = wd[25];
		end
		if (a[7:2] == 6'h0b && !svLock && |be[1:0])
		begin
			if (be[0]) mSv[7:0] = wd[7:0];
			if (be[1]) mSv[15:8] = wd[15:8];
			svLock = 1'b1;
		end
		if (a[7:2] == 6'h0b && !sidLock && |be[3:2])
		begin
			if (be[2]) mSid[7:0] = wd[23:16];
			if (be[3]) mSid[15:8] = wd[31:24];
			sidLock = 1'b1;
		end
	endtask

	// one config access; answer is looked at in its single ack cycle
	task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
		logic [31:0] expd;
		@(posedge clk_sys);
		#1;
		expd = wr ? 32'h00000000 : exp_read(a);
		cfgReq = '{1'b1, wr, a, be, wd};
		@(posedge clk_sys);
		#1;
		cfgReq.valid = 1'b0;
		check1(cfgAck, 1'b1);
		check32(cfgRdata, expd);
		if (wr)
			model_write(a, be, wd);
		check32(aperture_base, exp_base());
		check32({sIdent, svIdent}, {mSid, mSv});
	endtask

	// a stored bit 25 is dropped while the 64 MB size is selected
	task automatic set_size(input logic v);
		@(posedge clk_sys);
		#1;
		sizeSel = v;
		if (!v)
			mB25 = 1'b0;
	endtask

	task automatic lookup(input logic [31:0] a, input logic en);
		logic inR;
		@(posedge clk_sys);
		#1;
		apReqValid = 1'b1;
		apReqAddr = a;
		accEn = en;
		inR = !mInt && a[31:26] == mHi && (!sizeSel || a[25] == mB25);
		@(posedge clk_sys);
		#1;
		apReqValid = 1'b0;
		check1(apHit, inR & en);
		check1(apRefused, inR & ~en);
	endtask

	task automatic do_reset(input logic pin);
		rstn = 1'b0;
		modePin = pin;
		sizeSel = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		check1(cfgAck, 1'b0);
		check32(aperture_base, 32'h00000008);
		rstn = 1'b1;
		repeat (5) @(posedge clk_sys);
		#1;
		{mHi, mB25, mSv, mSid, svLock, sidLock} = '0;
		mInt = pin;
		check1(intMode, pin);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	//------------------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------------------
	initial
	begin
		{rstn, sizeSel, accEn, modePin, apReqValid, mInt} = '0;
		{cycles, num_errors, num_checks} = '0;
		cfgReq = '0;
		apReqAddr = 32'h00000000;
		void'($urandom(96));
		do_reset(1'b0);
		cfg(0, 8'h10, 4'hf, 32'h0);
		cfg(0, 8'h2e, 4'hf, 32'h0);
		cfg(1, 8'h34, 4'hf, 32'hffffffff);
		cfg(0, 8'h34, 4'hf, 32'h0);
		cfg(1, 8'h40, 4'hf, 32'hffffffff);
		cfg(0, 8'h40, 4'hf, 32'h0);
		$display("test reset_values done");
		// size chosen before base placement, then bit 25 toggles programmable
		set_size(1'b1);
		cfg(1, 8'h10, 4'h8, 32'hffffffff);
		cfg(0, 8'h10, 4'hf, 32'h0);
		set_size(1'b0);
		cfg(0, 8'h10, 4'hf, 32'h0);
		set_size(1'b1);
		cfg(0, 8'h10, 4'hf, 32'h0);
		for (int i = 0; i < 30; i++)
		begin
			if (i % 5 == 0) set_size(1'($urandom));
			cfg(1, 8'h10, 4'($urandom), $urandom);
			cfg(0, 8'h10, 4'hf, 32'h0);
		end
		$display("test aperture_base done");
		for (int i = 0; i < 40; i++)
		begin
			logic [31:0] a;
			a = $urandom;
			if (i % 2 == 0) a[31:25] = {mHi, 1'($urandom)};
			lookup(a, 1'($urandom));
		end
		$display("test aperture_lookup done");
		// boot code programs each ident once; later writes bounce
		cfg(1, 8'h2c, 4'h0, $urandom);
		cfg(1, 8'h2c, 4'h1, $urandom);
		cfg(1, 8'h2e, 4'h4, $urandom);
		cfg(1, 8'h2c, 4'hf, $urandom);
		cfg(0, 8'h2c, 4'hf, 32'h0);
		do_reset(1'b0);
		cfg(0, 8'h2c, 4'hf, 32'h0);
		cfg(1, 8'h2c, 4'hf, $urandom);
		cfg(0, 8'h2c, 4'hf, 32'h0);
		$display("test write_once done");
		do_reset(1'b1);
		cfg(0, 8'h10, 4'hf, 32'h0);
		cfg(1, 8'h10, 4'hf, 32'hfc000000);
		lookup(32'h00000000, 1'b1);
		lookup(32'h00000000, 1'b0);
		cfg(0, 8'h34, 4'hf, 32'h0);
		$display("test integrated_mode done");
		report_and_stop();
	end
endmodule

`default_nettype wire
